/* logic/fan_drive_pkg.sv */
// Constants, register map and types shared by the fan drive channel files
package fan_drive_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_HOT_WATCH = 8'hc7;
  localparam logic [7:0] ADDR_SRC_SEL   = 8'hc8;
  localparam logic [7:0] ADDR_OVR_LOCK  = 8'hc9;
  localparam logic [7:0] ADDR_SPINUP    = 8'hca;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;

  // Reset values
  localparam logic [7:0] RST_HOT_WATCH  = 8'h11;
  localparam logic [7:0] RST_CHANNEL    = 8'h00;

  // Source select fields; reserved bits 5 and 7 read as zero
  localparam int         BIT_BIND_TABLE0 = 0;
  localparam int         NUM_TABLES      = 4;
  localparam int         BIT_BIND_CPU    = 4;
  localparam int         BIT_BIND_REG    = 6;
  localparam logic [7:0] SRC_SEL_MASK    = 8'h5f;

  // Override and lock fields
  localparam int BIT_OVR_EN    = 0;
  localparam int BIT_INV       = 1;
  localparam int BIT_LOCK_EN   = 2;
  localparam int BIT_LOCK_FLAG = 3;
  localparam int MANUAL_LSB    = 4;

  // Spin-up fields
  localparam int BOOST_DUTY_LSB = 0;
  localparam int DUR_MSB_BIT    = 4;
  localparam int DUR_LOW_LSB    = 5;

  // Monitoring interval field
  localparam int HOT_CODE_LSB   = 0;
  localparam int HOT_CODES      = 10;

  // Duty codes
  localparam int         DUTY_W    = 4;
  localparam logic [3:0] DUTY_ZERO = 4'h0;
  localparam logic [3:0] DUTY_FULL = 4'hf;

  // Timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned MS_CYCLES    = CLK_HZ / MS_PER_S;
  localparam int unsigned PWM_SLOT_CYC = 64;

  // Monitoring interval per code, in ms (0.73 s .. 372 s)
  localparam int unsigned HOT_WATCH_MS [0:9] = '{
    730, 1460, 2900, 5800, 11700, 23300, 46600, 93200, 186000, 372000
  };
  localparam int HOT_MS_W = 19;

  // Spin-up time per 4-bit duration code, in ms; code 0 disables
  localparam int unsigned BOOST_MS [0:15] = '{
    0, 100, 250, 400, 700, 1000, 2000, 4000,
    6000, 8000, 10000, 12000, 14000, 16000, 18000, 20000
  };
  localparam int BOOST_MS_W = 15;

  typedef enum logic [1:0] {
    SPIN_OFF   = 2'b00,
    SPIN_BOOST = 2'b01,
    SPIN_RUN   = 2'b11
  } spin_state_t;

endpackage

/* logic/fan_pwm_wave.sv */
// Pulse-width waveform generator with selectable output polarity
`timescale 1ns/10ps

module fan_pwm_wave #(
  parameter int SLOT_CYCLES = fan_drive_pkg::PWM_SLOT_CYC
) (
  // Clock and reset
  input  wire logic                              i_core_clk,
  input  wire logic                              i_rst_n,
  // Control
  input  wire logic [fan_drive_pkg::DUTY_W-1:0]  i_duty,
  input  wire logic                              i_invert,
  // Output
  output logic                                   o_wave
);

  localparam int SLOT_W = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;
  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_CYCLES - 1);
  // Period has one slot less than the code range, so the top code never goes low
  localparam logic [fan_drive_pkg::DUTY_W-1:0] PHASE_LAST = fan_drive_pkg::DUTY_FULL - 4'h1;

  if (SLOT_CYCLES < 1) begin : g_bad_slot
    $error("SLOT_CYCLES must be at least one");
  end

  typedef struct packed {
    logic [SLOT_W-1:0]               slot_cnt;
    logic [fan_drive_pkg::DUTY_W-1:0] phase;
    logic                            wave;
  } wave_state_t;

  wave_state_t st_r;
  wave_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (st_r.slot_cnt == SLOT_LAST) begin
      st_nxt.slot_cnt = '0;
      st_nxt.phase    = (st_r.phase == PHASE_LAST) ? '0 : st_r.phase + 4'h1;
    end else begin
      st_nxt.slot_cnt = st_r.slot_cnt + SLOT_W'(1);
    end
    st_nxt.wave = (st_r.phase < i_duty) ^ i_invert;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_wave = st_r.wave;

  AST_FULL_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_duty == fan_drive_pkg::DUTY_FULL && !i_invert) |=> o_wave)
    else $error("full duty not continuously high");

  AST_FULL_LOW: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_duty == fan_drive_pkg::DUTY_FULL && i_invert) |=> !o_wave)
    else $error("inverted full duty not continuously low");

endmodule

/* logic/fan_drive_channel_control.sv */
// Fan drive channel control: source binding, override, lock, spin-up, registers
//
// Behaviour
// - Interval code 0h..9h selects 0.73 s up to 372 s; Ah..Fh reserved.
// - Source bits 0..3 bind the output to lookup tables one to four.
// - Source bit 4 binds the output to the processor-hot ramp.
// - Source bit 6 binds the regulator-hot ramp; bits 5 and 7 reserved.
// - With several bound sources, the greatest requested duty is driven.
// - Tables request duty by lookup, hot inputs by ramp up and down.
// - Control bit 0 enables manual override using duty code in bits 7:4.
// - Polarity clear: full duty is high; set: full duty is low.
// - With lock enable, a bound processor-hot event sets the lock flag.
// - Lock flag holds full duty until software writes it zero.
// - Lock flag stays writable under the global write lock.
// - Reading the manual duty field returns the duty actually driven.
// - During spin-up the manual duty field reads 0h.
// - Spin-up duty code in bits 3:0; zero disables spin-up.
// - Duty going from zero to nonzero starts spin-up for the set time.
// - Duration code is bit 4 then bits 7:5; times 100 ms to 20 s.
// - Interval held in bits 3:0 of its register, reset value 11h.
// - Four-bit duty codes take 16 values, 13 map to table steps.
`timescale 1ns/10ps

module fan_drive_channel_control #(
  parameter int unsigned MS_CYCLES   = fan_drive_pkg::MS_CYCLES,
  parameter int          SLOT_CYCLES = fan_drive_pkg::PWM_SLOT_CYC
) (
  // Clock and reset
  input  wire logic                                     i_core_clk,
  input  wire logic                                     i_rst_n,
  // Register port
  input  wire logic [7:0]                               i_reg_addr,
  input  wire logic                                     i_reg_wr,
  input  wire logic                                     i_reg_rd,
  input  wire logic [7:0]                               i_reg_wdata,
  input  wire logic                                     i_cfg_write_lock,
  output logic      [7:0]                               o_reg_rdata,
  // Duty requests from lookup tables and ramp generators
  input  wire logic [3:0][fan_drive_pkg::DUTY_W-1:0]    i_table_duty,
  input  wire logic [fan_drive_pkg::DUTY_W-1:0]         i_cpu_ramp_duty,
  input  wire logic [fan_drive_pkg::DUTY_W-1:0]         i_reg_ramp_duty,
  // Processor-hot pin, asynchronous, active high
  input  wire logic                                     i_cpu_thermal_throttle_in,
  // Status and drive
  output logic [fan_drive_pkg::DUTY_W-1:0]              o_duty_code,
  output logic                                          o_spinup_active,
  output logic [fan_drive_pkg::HOT_MS_W-1:0]            o_hot_watch_ms,
  output logic                                          o_hot_watch_valid,
  output logic                                          o_fan_drive_out_a
);

  localparam int TICK_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);
  localparam logic [fan_drive_pkg::BOOST_MS_W-1:0] MS_ONE = 15'h0001;

  if (MS_CYCLES < 1) begin : g_bad_ms
    $error("MS_CYCLES must be at least one");
  end

  typedef struct packed {
    logic                                    thr_meta;
    logic                                    thr_sync;
    logic [7:0]                              hot_watch;
    logic [7:0]                              src_sel;
    logic                                    ovr_en;
    logic                                    output_polarity_flip;
    logic                                    lock_en;
    logic                                    lock_flag;
    logic [fan_drive_pkg::DUTY_W-1:0]        manual;
    logic [7:0]                              spin_cfg;
    fan_drive_pkg::spin_state_t              spin;
    logic [TICK_W-1:0]                       tick_cnt;
    logic [fan_drive_pkg::BOOST_MS_W-1:0]    ms_left;
    logic [fan_drive_pkg::DUTY_W-1:0]        duty;
    logic                                    spin_act;
    logic [7:0]                              rdata;
    logic [fan_drive_pkg::HOT_MS_W-1:0]      hot_ms;
    logic                                    hot_valid;
  } chan_state_t;

  chan_state_t st_r;
  chan_state_t st_nxt;

  logic [fan_drive_pkg::DUTY_W-1:0] req_code;
  logic [fan_drive_pkg::DUTY_W-1:0] boost_code;
  logic [3:0]                       dur_code;
  logic [3:0]                       hot_code;
  logic                             lock_event;
  logic                             wr_open;

  assign boost_code = st_r.spin_cfg[fan_drive_pkg::BOOST_DUTY_LSB +: fan_drive_pkg::DUTY_W];
  assign dur_code   = {st_r.spin_cfg[fan_drive_pkg::DUR_MSB_BIT],
                       st_r.spin_cfg[fan_drive_pkg::DUR_LOW_LSB +: 3]};
  assign hot_code   = st_r.hot_watch[fan_drive_pkg::HOT_CODE_LSB +: 4];
  assign lock_event = st_r.lock_en && st_r.thr_sync && st_r.src_sel[fan_drive_pkg::BIT_BIND_CPU];
  assign wr_open    = i_reg_wr && !i_cfg_write_lock;

  // Largest request among the bound sources; lookup codes and ramp codes share
  // one 16-value scale, so a plain magnitude compare is enough
  always_comb begin
    req_code = fan_drive_pkg::DUTY_ZERO;
    for (int t = 0; t < fan_drive_pkg::NUM_TABLES; t++) begin
      if (st_r.src_sel[fan_drive_pkg::BIT_BIND_TABLE0 + t] && i_table_duty[t] > req_code) begin
        req_code = i_table_duty[t];
      end
    end
    if (st_r.src_sel[fan_drive_pkg::BIT_BIND_CPU] && i_cpu_ramp_duty > req_code) begin
      req_code = i_cpu_ramp_duty;
    end
    if (st_r.src_sel[fan_drive_pkg::BIT_BIND_REG] && i_reg_ramp_duty > req_code) begin
      req_code = i_reg_ramp_duty;
    end
    if (st_r.ovr_en && st_r.manual > req_code) begin
      req_code = st_r.manual;
    end
  end

  always_comb begin
    st_nxt = st_r;

    // Pin synchroniser
    st_nxt.thr_meta = i_cpu_thermal_throttle_in;
    st_nxt.thr_sync = st_r.thr_meta;

    // Register writes; the lock flag bypasses the global write lock
    if (wr_open && i_reg_addr == fan_drive_pkg::ADDR_HOT_WATCH) begin
      st_nxt.hot_watch = i_reg_wdata;
    end
    if (wr_open && i_reg_addr == fan_drive_pkg::ADDR_SRC_SEL) begin
      st_nxt.src_sel = i_reg_wdata & fan_drive_pkg::SRC_SEL_MASK;
    end
    if (wr_open && i_reg_addr == fan_drive_pkg::ADDR_OVR_LOCK) begin
      st_nxt.ovr_en  = i_reg_wdata[fan_drive_pkg::BIT_OVR_EN];
      st_nxt.output_polarity_flip     = i_reg_wdata[fan_drive_pkg::BIT_INV];
      st_nxt.lock_en = i_reg_wdata[fan_drive_pkg::BIT_LOCK_EN];
      st_nxt.manual  = i_reg_wdata[fan_drive_pkg::MANUAL_LSB +: fan_drive_pkg::DUTY_W];
    end
    if (wr_open && i_reg_addr == fan_drive_pkg::ADDR_SPINUP) begin
      st_nxt.spin_cfg = i_reg_wdata;
    end
    // Writing one is ignored; a coincident event beats the clear
    if (i_reg_wr && i_reg_addr == fan_drive_pkg::ADDR_OVR_LOCK &&
        !i_reg_wdata[fan_drive_pkg::BIT_LOCK_FLAG]) begin
      st_nxt.lock_flag = 1'b0;
    end
    if (lock_event) begin
      st_nxt.lock_flag = 1'b1;
    end

    // Spin-up sequencing
    st_nxt.tick_cnt = '0;
    case (st_r.spin)
      fan_drive_pkg::SPIN_OFF: begin
        if (req_code != fan_drive_pkg::DUTY_ZERO && !st_r.lock_flag) begin
          if (boost_code != fan_drive_pkg::DUTY_ZERO && dur_code != 4'h0) begin
            st_nxt.spin    = fan_drive_pkg::SPIN_BOOST;
            st_nxt.ms_left = fan_drive_pkg::BOOST_MS_W'(fan_drive_pkg::BOOST_MS[dur_code]);
          end else begin
            st_nxt.spin = fan_drive_pkg::SPIN_RUN;
          end
        end else if (st_r.lock_flag) begin
          st_nxt.spin = fan_drive_pkg::SPIN_RUN;
        end
      end
      fan_drive_pkg::SPIN_BOOST: begin
        if (st_r.tick_cnt == TICK_LAST) begin
          if (st_r.ms_left <= MS_ONE) begin
            st_nxt.spin = fan_drive_pkg::SPIN_RUN;
          end else begin
            st_nxt.ms_left = st_r.ms_left - MS_ONE;
          end
        end else begin
          st_nxt.tick_cnt = st_r.tick_cnt + TICK_W'(1);
        end
      end
      fan_drive_pkg::SPIN_RUN: begin
        if (req_code == fan_drive_pkg::DUTY_ZERO && !st_r.lock_flag) begin
          st_nxt.spin = fan_drive_pkg::SPIN_OFF;
        end
      end
      default: begin
        st_nxt.spin = fan_drive_pkg::SPIN_OFF;
      end
    endcase

    // Driven duty: lock first, then spin-up boost, then the winning request
    if (st_r.lock_flag) begin
      st_nxt.duty = fan_drive_pkg::DUTY_FULL;
    end else if (st_r.spin == fan_drive_pkg::SPIN_BOOST) begin
      st_nxt.duty = boost_code;
    end else if (st_r.spin == fan_drive_pkg::SPIN_RUN) begin
      st_nxt.duty = req_code;
    end else begin
      st_nxt.duty = fan_drive_pkg::DUTY_ZERO;
    end
    st_nxt.spin_act = (st_nxt.spin == fan_drive_pkg::SPIN_BOOST);

    // Monitoring interval decode; reserved codes report invalid
    if (hot_code < 4'(fan_drive_pkg::HOT_CODES)) begin
      st_nxt.hot_ms    = fan_drive_pkg::HOT_MS_W'(fan_drive_pkg::HOT_WATCH_MS[hot_code]);
      st_nxt.hot_valid = 1'b1;
    end else begin
      st_nxt.hot_ms    = '0;
      st_nxt.hot_valid = 1'b0;
    end

    // Read port, registered; unmapped addresses read zero
    if (i_reg_rd) begin
      case (i_reg_addr)
        fan_drive_pkg::ADDR_HOT_WATCH: st_nxt.rdata = st_r.hot_watch;
        fan_drive_pkg::ADDR_SRC_SEL:   st_nxt.rdata = st_r.src_sel;
        fan_drive_pkg::ADDR_OVR_LOCK: begin
          st_nxt.rdata = {st_r.spin_act ? fan_drive_pkg::DUTY_ZERO : st_r.duty,
                          st_r.lock_flag, st_r.lock_en, st_r.output_polarity_flip, st_r.ovr_en};
        end
        fan_drive_pkg::ADDR_SPINUP:    st_nxt.rdata = st_r.spin_cfg;
        default:                       st_nxt.rdata = fan_drive_pkg::RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_r           <= '0;
      st_r.hot_watch <= fan_drive_pkg::RST_HOT_WATCH;
      st_r.src_sel   <= fan_drive_pkg::RST_CHANNEL;
      st_r.spin_cfg  <= fan_drive_pkg::RST_CHANNEL;
      st_r.spin      <= fan_drive_pkg::SPIN_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  fan_pwm_wave #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_wave (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_duty     (st_r.duty),
    .i_invert   (st_r.output_polarity_flip),
    .o_wave     (o_fan_drive_out_a)
  );

  assign o_reg_rdata       = st_r.rdata;
  assign o_duty_code       = st_r.duty;
  assign o_spinup_active   = st_r.spin_act;
  assign o_hot_watch_ms    = st_r.hot_ms;
  assign o_hot_watch_valid = st_r.hot_valid;

  AST_LOCK_FULL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    st_r.lock_flag |=> (o_duty_code == fan_drive_pkg::DUTY_FULL))
    else $error("locked channel not at full duty");

  AST_LOCK_NEEDS_EN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!st_r.lock_en && !st_r.lock_flag) |=> !st_r.lock_flag)
    else $error("lock flag set without lock enable");

  AST_LOCK_SETS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    lock_event |=> st_r.lock_flag)
    else $error("bound processor-hot event did not latch lock");

  AST_LOCK_HOLDS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r.lock_flag && !(i_reg_wr && i_reg_addr == fan_drive_pkg::ADDR_OVR_LOCK &&
     !i_reg_wdata[fan_drive_pkg::BIT_LOCK_FLAG])) |=> st_r.lock_flag)
    else $error("lock flag dropped without a software clear");

  AST_LOCK_WR_UNDER_GLOBAL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_cfg_write_lock && i_reg_addr == fan_drive_pkg::ADDR_OVR_LOCK &&
     !i_reg_wdata[fan_drive_pkg::BIT_LOCK_FLAG] && !lock_event) |=> !st_r.lock_flag)
    else $error("lock flag clear blocked by write lock");

  AST_SPIN_READS_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == fan_drive_pkg::ADDR_OVR_LOCK && o_spinup_active)
      |=> (o_reg_rdata[7:4] == fan_drive_pkg::DUTY_ZERO))
    else $error("manual duty field not zero during spin-up");

  AST_READ_DRIVEN_DUTY: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == fan_drive_pkg::ADDR_OVR_LOCK && !o_spinup_active)
      |=> (o_reg_rdata[7:4] == $past(o_duty_code)))
    else $error("manual duty field does not show driven duty");

  AST_SPIN_START: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r.spin == fan_drive_pkg::SPIN_OFF && req_code != fan_drive_pkg::DUTY_ZERO &&
     !st_r.lock_flag && boost_code != fan_drive_pkg::DUTY_ZERO && dur_code != 4'h0)
      |=> o_spinup_active ##1 (o_duty_code == $past(boost_code) || st_r.lock_flag))
    else $error("spin-up did not start on duty leaving zero");

  AST_NO_SPIN_ZERO_DUTY: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r.spin == fan_drive_pkg::SPIN_OFF && boost_code == fan_drive_pkg::DUTY_ZERO)
      |=> !o_spinup_active)
    else $error("spin-up ran with zero spin-up duty");

  AST_MAX_WINS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r.spin == fan_drive_pkg::SPIN_RUN && !st_r.lock_flag &&
     st_r.src_sel[fan_drive_pkg::BIT_BIND_TABLE0])
      |=> (o_duty_code >= $past(i_table_duty[0])))
    else $error("driven duty below a bound table request");

  AST_OVERRIDE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r.spin == fan_drive_pkg::SPIN_RUN && !st_r.lock_flag && st_r.ovr_en)
      |=> (o_duty_code >= $past(st_r.manual)))
    else $error("override duty not applied");

  AST_HOT_RESERVED: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (hot_code >= 4'(fan_drive_pkg::HOT_CODES)) |=> (!o_hot_watch_valid && o_hot_watch_ms == '0))
    else $error("reserved interval code reported valid");

endmodule

/* bench/fan_model.sv */
// Behavioural fan load that tallies drive-high cycles over one pulse period
`timescale 1ns/10ps

module fan_model #(
  parameter int PERIOD = 15
) (
  // Clock
  input  wire logic       i_core_clk,
  // Drive from the channel
  input  wire logic       i_drive,
  // High cycles seen over one period
  output logic      [4:0] o_high_cnt
);
  logic [PERIOD-1:0] hist_r;

  // A fan only feels the average drive, so one pulse period of history is enough
  always_ff @(posedge i_core_clk) begin
    hist_r <= {hist_r[PERIOD-2:0], i_drive};
  end

  assign o_high_cnt = 5'($countones(hist_r));
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the fan drive channel control block
`timescale 1ns/10ps

module tb_top;
  localparam int MS = 4;
  logic        clk, rst_n, wr, rd, wlock, pin;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] tbl;
  logic [3:0]  cpu, regr, duty;
  logic        spin, hvalid, pwm;
  logic [18:0] hms;
  logic [4:0]  fan_cnt;
  logic [7:0]  v;
  int          fail_count, comparisons, cyc, n, e;
  // Rows: source select, override byte, tables, cpu ramp, regulator ramp, expected duty
  logic [43:0] rows [0:11] = '{
    44'h01004321001, 44'h02004321002, 44'h04004321003, 44'h08004321004,
    44'h10004321909, 44'h400043210aa, 44'ha00043219a0, 44'h5f0043219aa,
    44'h007143219a7, 44'h01314325005, 44'h10e1432130e, 44'h00004321000};

  fan_drive_channel_control #(.MS_CYCLES(MS), .SLOT_CYCLES(1)) i_dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .i_cfg_write_lock(wlock), .o_reg_rdata(rdata),
    .i_table_duty(tbl), .i_cpu_ramp_duty(cpu), .i_reg_ramp_duty(regr),
    .i_cpu_thermal_throttle_in(pin), .o_duty_code(duty), .o_spinup_active(spin),
    .o_hot_watch_ms(hms), .o_hot_watch_valid(hvalid), .o_fan_drive_out_a(pwm));

  fan_model #(.PERIOD(15)) i_fan (.i_core_clk(clk), .i_drive(pwm), .o_high_cnt(fan_cnt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    // Idle edge so a following call never re-raises the strobe in the same step
    tick(1);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk("read data", {24'h0, exp}, {24'h0, rdata});
    tick(1);
  endtask

  task automatic summarize;
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cut a hang short well beyond the longest spin-up run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    {rst_n, wr, rd, wlock, pin, addr, wdata, tbl, cpu, regr} = '0;
    tick(3);
    rst_n = 1'b1;
    tick(2);
    chk("interval ms", 32'd1460, {13'h0, hms});
    reg_rd(8'hc7, 8'h11);
    reg_rd(8'hc8, 8'h00);
    reg_rd(8'hc9, 8'h00);
    reg_rd(8'hca, 8'h00);
    reg_rd(8'hc6, 8'h00);
    for (int r = 0; r < 12; r++) begin
      reg_wr(8'hc8, rows[r][43:36]);
      reg_wr(8'hc9, rows[r][35:28]);
      tbl = rows[r][27:12];
      cpu = rows[r][11:8];
      regr = rows[r][7:4];
      tick(22);
      chk("duty", {28'h0, rows[r][3:0]}, {28'h0, duty});
      chk("fan high", {28'h0, rows[r][3:0]}, {27'h0, fan_cnt});
      reg_rd(8'hc8, rows[r][43:36] & 8'h5f);
      reg_rd(8'hc9, {rows[r][3:0], rows[r][31:28]});
    end
    for (int c = 0; c < 16; c++) begin
      reg_wr(8'hc7, {4'ha, 4'(c)});
      tick(2);
      e = (c < 10) ? fan_drive_pkg::HOT_WATCH_MS[c] : 0;
      chk("interval ms", e, {13'h0, hms});
      chk("interval valid", {31'h0, c < 10}, {31'h0, hvalid});
      reg_rd(8'hc7, {4'ha, 4'(c)});
    end
    reg_wr(8'hc8, 8'h00);
    reg_wr(8'hc9, 8'hf3);
    tick(22);
    chk("fan high inverted", 32'd0, {27'h0, fan_cnt});
    reg_wr(8'hc9, 8'h53);
    tick(22);
    chk("fan high inverted", 32'd10, {27'h0, fan_cnt});
    reg_wr(8'hc9, 8'h00);
    reg_wr(8'hc8, 8'h10);
    cpu = 4'h2;
    pin = 1'b1;
    tick(8);
    reg_rd(8'hc9, 8'h20);
    reg_wr(8'hc9, 8'h04);
    tick(6);
    chk("duty", 32'hf, {28'h0, duty});
    reg_rd(8'hc9, 8'hfc);
    pin = 1'b0;
    wlock = 1'b1;
    reg_wr(8'hc8, 8'h01);
    reg_rd(8'hc8, 8'h10);
    tick(4);
    chk("duty", 32'hf, {28'h0, duty});
    reg_wr(8'hc9, 8'h04);
    tick(4);
    reg_rd(8'hc9, 8'h24);
    wlock = 1'b0;
    reg_wr(8'hc9, 8'h00);
    reg_wr(8'hc8, 8'h01);
    foreach (rows[k]) begin
      if (k < 4) begin
        v = (k == 0) ? 8'h2c : (k == 1) ? 8'h8c : (k == 2) ? 8'h1c : 8'h20;
        reg_wr(8'hca, v);
        tbl = 16'h0;
        tick(4);
        tbl = 16'h0003;
        n = cyc;
        tick(3);
        e = fan_drive_pkg::BOOST_MS[{v[4], v[7:5]}] * MS;
        chk("spin active", {31'h0, v[3:0] != 4'h0}, {31'h0, spin});
        if (v[3:0] != 4'h0) begin
          chk("spin duty", {28'h0, v[3:0]}, {28'h0, duty});
          reg_rd(8'hc9, 8'h00);
          while (spin === 1'b1 && cyc < n + 30000) begin
            tick(1);
          end
          // Boost starts one edge after the request appears, hence the extra edge
          chk("spin cycles", e + 1, cyc - n);
        end
        tick(2);
        chk("duty", 32'h3, {28'h0, duty});
      end
    end
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    tick(1);
    chk("duty", 32'h0, {28'h0, duty});
    chk("interval ms", 32'd1460, {13'h0, hms});
    reg_rd(8'hca, 8'h00);
    summarize();
  end
endmodule
